//--- verilog/vpw_pkg.sv
// shared constants, symbol codes and crc step for the vpw byte link controller
package vpw_pkg;
   // clocking: symbol timing resolution is 1 us at the normal rate
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_NS / 1_000_000;
   localparam int FAST_DIV = 4;
   localparam int FAST_TICK_CYC = TICK_CYC / FAST_DIV;
   localparam int DIV_W = 5;

   // symbol width counter
   localparam int CNT_W = 9;

   // receive thresholds in ticks (active and passive share edges a..d)
   localparam logic [CNT_W-1:0] RX_T_A_US = 9'h022;
   localparam logic [CNT_W-1:0] RX_T_B_US = 9'h060;
   localparam logic [CNT_W-1:0] RX_T_C_US = 9'h0a3;
   localparam logic [CNT_W-1:0] RX_T_D_US = 9'h0ef;
   localparam logic [CNT_W-1:0] RX_IFS_US = 9'h118;
   localparam logic [CNT_W-1:0] RX_BRK_US = 9'h118;

   // transmit nominal symbol widths in ticks
   localparam logic [CNT_W-1:0] TX_SHORT_US = 9'h040;
   localparam logic [CNT_W-1:0] TX_LONG_US = 9'h080;
   localparam logic [CNT_W-1:0] TX_SOF_US = 9'h0c8;
   localparam logic [CNT_W-1:0] TX_EOD_US = 9'h0c8;
   localparam logic [CNT_W-1:0] TX_SETTLE_US = 9'h004;

   // crc
   localparam logic [7:0] CRC_INIT = 8'hff;
   localparam logic [7:0] CRC_POLY = 8'h1d;
   localparam logic [7:0] CRC_RESIDUE = 8'hc4;

   // state vector codes
   localparam logic [7:0] SV_NONE = 8'h00;
   localparam logic [7:0] SV_EOF = 8'h04;
   localparam logic [7:0] SV_TXE = 8'h08;
   localparam logic [7:0] SV_IFR = 8'h0c;
   localparam logic [7:0] SV_RXF = 8'h10;
   localparam logic [7:0] SV_LOA = 8'h14;
   localparam logic [7:0] SV_CRC = 8'h18;
   localparam logic [7:0] SV_INV = 8'h1c;

   typedef enum logic [2:0] {
      SYM_BIT0, SYM_BIT1, SYM_SOF, SYM_INV, SYM_EOD, SYM_EOF, SYM_IDLE, SYM_BRK
   } vpw_sym_t;

   // one serial step of the frame crc, msb first
   function automatic logic [7:0] vpw_crc_step(input logic [7:0] crc, input logic b);
      logic fb;
      fb = crc[7] ^ b;
      vpw_crc_step = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
   endfunction : vpw_crc_step
endpackage : vpw_pkg

//--- verilog/vpw_crc8.sv
// serial frame crc register
`timescale 1ns/1ps
module vpw_crc8 (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // control
   input wire logic clr,
   input wire logic en,
   input wire logic bit_in,
   // result
   output logic [7:0] crc,
   output logic [7:0] crc_nx
);
   import vpw_pkg::*;
   logic [7:0] crc_q;

   assign crc_nx = vpw_crc_step(crc_q, bit_in);
   assign crc = crc_q;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         crc_q <= CRC_INIT;
      end else if (clr) begin
         crc_q <= CRC_INIT;
      end else if (en) begin
         crc_q <= crc_nx;
      end
   end
endmodule : vpw_crc8

//--- verilog/vpw_sym_dec.sv
// measures bus pulse widths and classifies received symbols
`timescale 1ns/1ps
module vpw_sym_dec (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // timing and line
   input wire logic tick,
   input wire logic rx_lvl,
   // decoded symbol, one-cycle pulse
   output logic sym_vld,
   output vpw_pkg::vpw_sym_t sym
);
   import vpw_pkg::*;
   logic lvl_q;
   logic [CNT_W-1:0] cnt_q;
   logic vld_q;
   vpw_sym_t sym_q;
   logic edge_seen;

   assign edge_seen = rx_lvl != lvl_q;
   assign sym_vld = vld_q;
   assign sym = sym_q;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lvl_q <= 1'b0;
         cnt_q <= '0;
      end else if (edge_seen) begin
         lvl_q <= rx_lvl;
         cnt_q <= '0;
      end else if (tick && cnt_q != '1) begin
         cnt_q <= cnt_q + 9'h001;
      end
   end

   // active pulses classify at their end, break while counting; passive timeouts fire while counting
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         vld_q <= 1'b0;
         sym_q <= SYM_IDLE;
      end else begin
         vld_q <= 1'b0;
         if (edge_seen && lvl_q) begin
            vld_q <= cnt_q < RX_BRK_US;
            if (cnt_q < RX_T_A_US) sym_q <= SYM_INV;
            else if (cnt_q < RX_T_B_US) sym_q <= SYM_BIT1;
            else if (cnt_q < RX_T_C_US) sym_q <= SYM_BIT0;
            else if (cnt_q < RX_T_D_US) sym_q <= SYM_SOF;
            else sym_q <= SYM_INV;
         end else if (edge_seen && cnt_q < RX_T_C_US) begin
            vld_q <= 1'b1;
            if (cnt_q < RX_T_A_US) sym_q <= SYM_INV;
            else if (cnt_q < RX_T_B_US) sym_q <= SYM_BIT0;
            else sym_q <= SYM_BIT1;
         end else if (tick && !edge_seen) begin
            if (lvl_q && cnt_q == RX_BRK_US - 9'h001) begin
               vld_q <= 1'b1;
               sym_q <= SYM_BRK;
            end else if (!lvl_q && cnt_q == RX_T_C_US - 9'h001) begin
               vld_q <= 1'b1;
               sym_q <= SYM_EOD;
            end else if (!lvl_q && cnt_q == RX_T_D_US - 9'h001) begin
               vld_q <= 1'b1;
               sym_q <= SYM_EOF;
            end else if (!lvl_q && cnt_q == RX_IFS_US - 9'h001) begin
               vld_q <= 1'b1;
               sym_q <= SYM_IDLE;
            end
         end
      end
   end
endmodule : vpw_sym_dec

//--- verilog/vpw_link_core.sv
// vpw link protocol handler: byte buffering, loopback, 4x receive, framing and bus errors
//
// Behaviour
// - completed receive byte is copied to holding register, full flag set (ifr flag instead for bytes after eod)
// - interrupt raised on received byte only when the enable bit is set
// - shift register takes next byte at once; new byte overwrites holding
// - finished transmit byte reloads from holding register; empty flag set in the same cycle
// - receive input comes from transmit output in digital loopback, else bus pin
// - 41.6 Kbps messages received when fast bit set; never transmitted
// - with fast bit clear, fast messages are noise and ignored
// - receive frames of any length; sof, crc and eod handled as usual
// - no maximum transmit length; frame runs while bytes keep coming
// - invalid own bits or misplaced framing stop drive, flag invalid symbol
// - failed receive crc flags crc error, interrupts, waits for end of frame
// - invalid symbol inside a received frame flags invalid symbol
// - eod/eof off byte boundary or active during own eod is framing error
// - bus stuck active blocks transmit until passive and idle
// - undrivable bus gives transmission error; abort until new cpu request
// - temporary faults clear without reset
// - break flags invalid symbol, cleared by vector read; wait idle then sof
// - break symbol is never transmitted
// - break clears fast bit and loads invalid symbol code into vector
// - dominant seen while sending recessive loses arbitration, stop at once
`timescale 1ns/1ps
module vpw_link_core (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // control bits
   input wire logic irq_enable_bit,
   input wire logic digital_loopback_bit,
   input wire logic fast_rx_wr,
   input wire logic fast_rx_wdata,
   // cpu data access
   input wire logic tx_wr,
   input wire logic [7:0] tx_wdata,
   input wire logic rx_rd,
   input wire logic sv_rd,
   // status
   output logic [7:0] rx_data,
   output logic rx_byte_full_flag,
   output logic inframe_resp_rx_flag,
   output logic tx_holding_empty_flag,
   output logic lost_arbitration_flag,
   output logic [7:0] state_vector_reg,
   output logic fast_receive_bit,
   output logic irq,
   // bus
   input wire logic bus_rx_in,
   output logic bus_tx_out
);
   import vpw_pkg::*;

   typedef enum {RX_WAIT_IDLE, RX_IDLE, RX_FRAME, RX_IFR, RX_WAIT_EOF} vpw_rx_st_t;
   typedef enum {TX_IDLE, TX_SOF, TX_BIT, TX_EOD} vpw_tx_st_t;

   function automatic logic [CNT_W-1:0] sym_len(input logic active, input logic b);
      sym_len = (active ^ b) ? TX_LONG_US : TX_SHORT_US;
   endfunction : sym_len

   logic rx_s1_q, rx_s2_q, rx_int;
   logic [DIV_W-1:0] rx_div_q, tx_div_q;
   logic rx_tick, tx_tick;
   logic sym_vld;
   vpw_sym_t sym;
   vpw_rx_st_t rx_st_q;
   vpw_tx_st_t tx_st_q;
   logic [7:0] rx_sh_q, rx_data_q, rx_crc, hold_q, tx_sh_q, tx_crc_nx;
   logic [2:0] rx_cnt_q, tx_bitn_q;
   logic nb_skip_q, idle_q, fast_q, out_q, crc_phase_q, prev_rec_q, hold_full_q;
   logic [CNT_W-1:0] tx_cnt_q, tx_len_q;
   logic rxf_q, ifr_q, txe_q, loa_q, crc_q, inv_q, eof_q, irq_q;
   logic [7:0] sv_q, sv_d;

   // two-flop synchroniser on the bus pin
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
      end else begin
         rx_s1_q <= bus_rx_in;
         rx_s2_q <= rx_s1_q;
      end
   end

   assign rx_int = digital_loopback_bit ? out_q : rx_s2_q;

   // receive tick runs four times faster in fast mode; transmit tick never does
   assign rx_tick = rx_div_q == DIV_W'((fast_q ? FAST_TICK_CYC : TICK_CYC) - 1);
   assign tx_tick = tx_div_q == DIV_W'(TICK_CYC - 1);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rx_div_q <= '0;
         tx_div_q <= '0;
      end else begin
         rx_div_q <= rx_tick ? '0 : rx_div_q + 5'h01;
         tx_div_q <= tx_tick ? '0 : tx_div_q + 5'h01;
      end
   end

   vpw_sym_dec u_sym (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .tick(rx_tick),
      .rx_lvl(rx_int),
      .sym_vld(sym_vld),
      .sym(sym)
   );

   // receive event decode
   logic is_bit, in_frame, data_bit, byte_done, brk_ev, sym_err, frame_err, eod_ok, crc_err, eof_ev;
   assign is_bit = sym_vld && (sym == SYM_BIT0 || sym == SYM_BIT1);
   assign in_frame = rx_st_q == RX_FRAME || rx_st_q == RX_IFR;
   assign data_bit = is_bit && (rx_st_q == RX_FRAME || (rx_st_q == RX_IFR && !nb_skip_q));
   assign byte_done = data_bit && rx_cnt_q == 3'h7;
   assign brk_ev = sym_vld && sym == SYM_BRK;
   assign sym_err = in_frame && sym_vld && (sym == SYM_INV || sym == SYM_SOF);
   assign frame_err = in_frame && sym_vld && (sym == SYM_EOD || sym == SYM_EOF) && rx_cnt_q != 3'h0;
   assign eod_ok = rx_st_q == RX_FRAME && sym_vld && sym == SYM_EOD && rx_cnt_q == 3'h0;
   assign crc_err = eod_ok && rx_crc != CRC_RESIDUE;
   assign eof_ev = sym_vld && sym == SYM_EOF && (in_frame || rx_st_q == RX_WAIT_EOF);

   vpw_crc8 u_rx_crc (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clr(rx_st_q == RX_IDLE),
      .en(data_bit && rx_st_q == RX_FRAME),
      .bit_in(sym == SYM_BIT1),
      .crc(rx_crc),
      .crc_nx()
   );

   // receive state: frames have no length limit, only symbols end them
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rx_st_q <= RX_WAIT_IDLE;
      end else if (brk_ev) begin
         rx_st_q <= RX_WAIT_IDLE;
      end else if (sym_vld) begin
         unique case (rx_st_q)
            RX_WAIT_IDLE: if (sym == SYM_IDLE) rx_st_q <= RX_IDLE;
            RX_IDLE: if (sym == SYM_SOF) rx_st_q <= RX_FRAME;
            RX_FRAME: begin
               if (sym_err || frame_err || crc_err) rx_st_q <= RX_WAIT_EOF;
               else if (eod_ok) rx_st_q <= RX_IFR;
               else if (sym == SYM_EOF) rx_st_q <= RX_IDLE;
            end
            RX_IFR: begin
               if (sym_err || frame_err) rx_st_q <= RX_WAIT_EOF;
               else if (sym == SYM_EOF) rx_st_q <= RX_IDLE;
            end
            RX_WAIT_EOF: if (sym == SYM_EOF || sym == SYM_IDLE) rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // receive shift register and holding register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rx_sh_q <= '0;
         rx_cnt_q <= '0;
         nb_skip_q <= 1'b0;
         rx_data_q <= '0;
      end else begin
         if (rx_st_q == RX_IDLE || eod_ok) begin
            rx_cnt_q <= '0;
            nb_skip_q <= eod_ok;
         end else if (is_bit && rx_st_q == RX_IFR && nb_skip_q) begin
            nb_skip_q <= 1'b0;
         end else if (data_bit) begin
            rx_sh_q <= {rx_sh_q[6:0], sym == SYM_BIT1};
            rx_cnt_q <= rx_cnt_q + 3'h1;
         end
         if (byte_done) rx_data_q <= {rx_sh_q[6:0], sym == SYM_BIT1};
      end
   end

   // bus idle: idle symbol seen, kept through eod and eof, cleared by any other symbol
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         idle_q <= 1'b0;
      end else if (sym_vld) begin
         idle_q <= sym == SYM_IDLE || (idle_q && (sym == SYM_EOD || sym == SYM_EOF));
      end
   end

   // transmit engine
   logic tx_busy, last_bit, load_hold, load_crc, sym_end, tx_start, chk, tx_err_ev, loa_ev, tx_abort, take;
   logic [7:0] nxt_sh;
   assign tx_busy = tx_st_q != TX_IDLE;
   assign tx_start = !tx_busy && tx_tick && hold_full_q && rx_st_q == RX_IDLE && idle_q && !rx_int
      && !fast_q;
   assign last_bit = tx_bitn_q == 3'h7;
   assign load_hold = last_bit && !crc_phase_q && hold_full_q;
   assign load_crc = last_bit && !crc_phase_q && !hold_full_q;
   assign nxt_sh = load_hold ? hold_q : (load_crc ? ~tx_crc_nx : {tx_sh_q[6:0], 1'b0});
   assign sym_end = tx_tick && tx_cnt_q == tx_len_q - 9'h001;
   assign chk = tx_cnt_q >= TX_SETTLE_US && rx_int != out_q;
   // passive while bus is active after our own recessive bit: arbitration lost
   assign loa_ev = chk && !out_q && tx_st_q == TX_BIT && (prev_rec_q || tx_sh_q[7]);
   assign tx_err_ev = chk && ((tx_st_q == TX_EOD)
      || ((tx_st_q == TX_SOF || tx_st_q == TX_BIT) && !loa_ev));
   assign tx_abort = tx_busy && (tx_err_ev || loa_ev || sym_err || frame_err || brk_ev);
   assign take = tx_start || (tx_st_q == TX_BIT && sym_end && load_hold && !tx_abort);

   vpw_crc8 u_tx_crc (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clr(tx_start),
      .en(tx_st_q == TX_BIT && sym_end && !crc_phase_q),
      .bit_in(tx_sh_q[7]),
      .crc(),
      .crc_nx(tx_crc_nx)
   );

   // symbol widths come from sof, bit and eod only, so no break can be sent
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tx_st_q <= TX_IDLE;
         out_q <= 1'b0;
         tx_cnt_q <= '0;
         tx_len_q <= TX_SOF_US;
         tx_sh_q <= '0;
         tx_bitn_q <= '0;
         crc_phase_q <= 1'b0;
         prev_rec_q <= 1'b0;
      end else if (tx_abort) begin
         tx_st_q <= TX_IDLE;
         out_q <= 1'b0;
      end else if (tx_start) begin
         tx_st_q <= TX_SOF;
         out_q <= 1'b1;
         tx_cnt_q <= '0;
         tx_len_q <= TX_SOF_US;
         tx_sh_q <= hold_q;
         tx_bitn_q <= '0;
         crc_phase_q <= 1'b0;
         prev_rec_q <= 1'b0;
      end else if (tx_busy && sym_end) begin
         tx_cnt_q <= '0;
         unique case (tx_st_q)
            TX_SOF: begin
               tx_st_q <= TX_BIT;
               out_q <= 1'b0;
               tx_len_q <= sym_len(1'b0, tx_sh_q[7]);
            end
            TX_BIT: begin
               prev_rec_q <= out_q && tx_sh_q[7];
               if (last_bit && crc_phase_q) begin
                  tx_st_q <= TX_EOD;
                  out_q <= 1'b0;
                  tx_len_q <= TX_EOD_US;
               end else begin
                  tx_sh_q <= nxt_sh;
                  tx_bitn_q <= tx_bitn_q + 3'h1;
                  crc_phase_q <= crc_phase_q || load_crc;
                  out_q <= !out_q;
                  tx_len_q <= sym_len(!out_q, nxt_sh[7]);
               end
            end
            TX_EOD: tx_st_q <= TX_IDLE;
            TX_IDLE: tx_st_q <= TX_IDLE;
         endcase
      end else if (tx_busy && tx_tick) begin
         tx_cnt_q <= tx_cnt_q + 9'h001;
      end
   end

   // transmit holding register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hold_q <= '0;
         hold_full_q <= 1'b0;
      end else begin
         if (tx_wr) hold_q <= tx_wdata;
         if (tx_wr) hold_full_q <= 1'b1;
         else if (take || tx_abort) hold_full_q <= 1'b0;
      end
   end

   // fast receive bit, cleared by break
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) fast_q <= 1'b0;
      else if (brk_ev) fast_q <= 1'b0;
      else if (fast_rx_wr) fast_q <= fast_rx_wdata;
   end

   // sticky status flags: hardware set wins over the clear
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rxf_q <= 1'b0;
         ifr_q <= 1'b0;
      end else begin
         if (byte_done && rx_st_q == RX_FRAME) rxf_q <= 1'b1;
         else if (rx_rd || (sv_rd && sv_q == SV_RXF)) rxf_q <= 1'b0;
         if (byte_done && rx_st_q == RX_IFR) ifr_q <= 1'b1;
         else if (rx_rd || (sv_rd && sv_q == SV_IFR)) ifr_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         txe_q <= 1'b1;
         loa_q <= 1'b0;
      end else begin
         if (take || tx_abort) txe_q <= 1'b1;
         else if (tx_wr) txe_q <= 1'b0;
         if (loa_ev && tx_busy) loa_q <= 1'b1;
         else if (sv_rd && sv_q == SV_LOA) loa_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         crc_q <= 1'b0;
         inv_q <= 1'b0;
         eof_q <= 1'b0;
      end else begin
         if (crc_err) crc_q <= 1'b1;
         else if (sv_rd && sv_q == SV_CRC) crc_q <= 1'b0;
         if (sym_err || frame_err || brk_ev || (tx_busy && tx_err_ev)) inv_q <= 1'b1;
         else if (sv_rd && sv_q == SV_INV) inv_q <= 1'b0;
         if (eof_ev) eof_q <= 1'b1;
         else if (sv_rd && sv_q == SV_EOF) eof_q <= 1'b0;
      end
   end

   // state vector, highest priority source first
   assign sv_d = inv_q ? SV_INV : crc_q ? SV_CRC : loa_q ? SV_LOA : rxf_q ? SV_RXF : ifr_q ? SV_IFR
      : txe_q ? SV_TXE : eof_q ? SV_EOF : SV_NONE;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sv_q <= SV_NONE;
         irq_q <= 1'b0;
      end else begin
         sv_q <= sv_d;
         irq_q <= irq_enable_bit && sv_d != SV_NONE;
      end
   end

   assign rx_data = rx_data_q;
   assign rx_byte_full_flag = rxf_q;
   assign inframe_resp_rx_flag = ifr_q;
   assign tx_holding_empty_flag = txe_q;
   assign lost_arbitration_flag = loa_q;
   assign state_vector_reg = sv_q;
   assign fast_receive_bit = fast_q;
   assign irq = irq_q;
   assign bus_tx_out = out_q;
endmodule : vpw_link_core

//--- dv/vpw_link_core_sva.sv
// assertion checker on the vpw link core ports
`timescale 1ns/1ps
module vpw_link_core_sva (
   // clock and reset
   input logic ref_clk,
   input logic rstn,
   // cpu side
   input logic irq_enable_bit,
   input logic fast_rx_wr,
   input logic tx_wr,
   input logic rx_rd,
   input logic sv_rd,
   // status and bus
   input logic [7:0] rx_data,
   input logic rx_byte_full_flag,
   input logic inframe_resp_rx_flag,
   input logic tx_holding_empty_flag,
   input logic [7:0] state_vector_reg,
   input logic fast_receive_bit,
   input logic irq,
   input logic bus_tx_out
);
   import vpw_pkg::*;
   logic [1:0] up_q;
   logic [12:0] hi_q;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // irq lags the enable bit, so skip the first edges after reset
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) up_q <= 2'h0;
      else up_q <= {up_q[0], 1'b1};
   end
   // length of the current active drive in cycles
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) hi_q <= 13'h0;
      else hi_q <= bus_tx_out ? hi_q + 13'h1 : 13'h0;
   end
   property p_irq_gate;
      up_q[1] |-> irq == ($past(irq_enable_bit) && state_vector_reg != SV_NONE);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enable");
   property p_rx_hold;
      $changed(rx_data) |-> rx_byte_full_flag || inframe_resp_rx_flag;
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("rx data moved without flag");
   property p_rd_clr;
      rx_rd |=> $changed(rx_data) || (!rx_byte_full_flag && !inframe_resp_rx_flag);
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("read left full flag");
   property p_no_brk;
      int'(hi_q) < int'(RX_BRK_US) * TICK_CYC;
   endproperty
   a_no_brk: assert property (p_no_brk) else $error("drive as long as a break");
   property p_fast_no_tx;
      $rose(bus_tx_out) |-> !$past(fast_receive_bit);
   endproperty
   a_fast_no_tx: assert property (p_fast_no_tx) else $error("drive in fast mode");
   property p_brk_vec;
      $fell(fast_receive_bit) && !$past(fast_rx_wr) |=> state_vector_reg == SV_INV;
   endproperty
   a_brk_vec: assert property (p_brk_vec) else $error("break vector missing");
   property p_empty_drop;
      $fell(tx_holding_empty_flag) |-> $past(tx_wr);
   endproperty
   a_empty_drop: assert property (p_empty_drop) else $error("empty flag fell alone");
   property p_inv_stop;
      $changed(state_vector_reg) && state_vector_reg == SV_INV |-> !bus_tx_out;
   endproperty
   a_inv_stop: assert property (p_inv_stop) else $error("drive after invalid");
   property p_sv_clr;
      sv_rd && state_vector_reg == SV_INV |-> ##[2:3] state_vector_reg != SV_INV;
   endproperty
   a_sv_clr: assert property (p_sv_clr) else $error("vector read kept invalid");
   c_rx_byte: cover property ($rose(rx_byte_full_flag));
   c_brk: cover property ($fell(fast_receive_bit) ##1 state_vector_reg == SV_INV);
   c_tx_err: cover property ($fell(bus_tx_out) ##[1:4] state_vector_reg == SV_INV);
endmodule : vpw_link_core_sva
bind vpw_link_core vpw_link_core_sva u_sva (.ref_clk, .rstn, .irq_enable_bit, .fast_rx_wr, .tx_wr, .rx_rd,
   .sv_rd, .rx_data, .rx_byte_full_flag, .inframe_resp_rx_flag, .tx_holding_empty_flag, .state_vector_reg,
   .fast_receive_bit, .irq, .bus_tx_out);

//--- dv/vpw_node.sv
// bus node model that sends vpw frames and raw symbols
`timescale 1ns/1ps
module vpw_node (
   // clock
   input wire logic ref_clk,
   // line drive, high is active
   output logic drv
);
   import vpw_pkg::*;
   initial drv = 1'b0;
   // frame check byte as sent, already inverted
   function automatic logic [7:0] crc8(input logic [31:0] d, input int n);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 8 * n - 1; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1d : 8'h00);
      return ~c;
   endfunction : crc8
   task automatic sym(input logic act, input int t, input int tc);
      drv = act;
      repeat (t * tc) @(negedge ref_clk);
   endtask : sym
   // one to four bytes; bits alternate passive then active, msb first
   task automatic frame(input logic [31:0] d, input int n, input logic bad);
      logic [39:0] f;
      f = {d, crc8(d, n) ^ {7'h00, bad}};
      sym(1'b1, TX_SOF_US, FAST_TICK_CYC);
      for (int i = 8 * n + 7; i >= 0; i--)
         sym(~i[0], (f[i] == i[0]) ? TX_LONG_US : TX_SHORT_US, FAST_TICK_CYC);
      sym(1'b0, int'(RX_IFS_US) + 20, FAST_TICK_CYC);
   endtask : frame
endmodule : vpw_node

//--- dv/vpw_link_core_tb_top.sv
// self-checking bench for the vpw link core
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
`define WAITC(c, lim) begin wcnt = 0; while (!(c) && wcnt < (lim)) begin @(negedge ref_clk); wcnt++; end end
module vpw_link_core_tb_top;
   import vpw_pkg::*;
   typedef struct {logic [31:0] d; int n; logic ie; logic fast; logic bad; logic [7:0] vec;} vpw_row_t;
   vpw_row_t rows [4] = '{'{32'h3a, 1, 1'b1, 1'b1, 1'b0, SV_RXF}, '{32'h80ff5c, 3, 1'b0, 1'b1, 1'b0, SV_RXF},
      '{32'h77, 1, 1'b1, 1'b1, 1'b1, SV_CRC}, '{32'h77, 1, 1'b1, 1'b0, 1'b0, SV_TXE}};
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic irq_enable_bit = 1'b0;
   logic digital_loopback_bit = 1'b0;
   logic fast_rx_wr = 1'b0;
   logic fast_rx_wdata = 1'b0;
   logic tx_wr = 1'b0;
   logic [7:0] tx_wdata = 8'h00;
   logic rx_rd = 1'b0;
   logic sv_rd = 1'b0;
   logic stuck_hi = 1'b0;
   logic stuck_lo = 1'b0;
   logic [7:0] rx_data, state_vector_reg;
   logic rx_byte_full_flag, inframe_resp_rx_flag, tx_holding_empty_flag, lost_arbitration_flag;
   logic fast_receive_bit, irq, bus_tx_out, node_drv, bus_rx_in;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   int wcnt;
   // passive line is pulled low; faults override every driver
   assign bus_rx_in = stuck_hi | (~stuck_lo & (node_drv | bus_tx_out));
   vpw_link_core dut (.ref_clk, .rstn, .irq_enable_bit, .digital_loopback_bit, .fast_rx_wr, .fast_rx_wdata,
      .tx_wr, .tx_wdata, .rx_rd, .sv_rd, .rx_data, .rx_byte_full_flag, .inframe_resp_rx_flag,
      .tx_holding_empty_flag, .lost_arbitration_flag, .state_vector_reg, .fast_receive_bit, .irq,
      .bus_rx_in, .bus_tx_out);
   vpw_node u_node (.ref_clk(ref_clk), .drv(node_drv));
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic report_and_stop();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 100000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   task automatic pulse_fast(input logic v);
      fast_rx_wdata = v;
      fast_rx_wr = 1'b1;
      @(negedge ref_clk);
      fast_rx_wr = 1'b0;
   endtask : pulse_fast
   // written only while the holding register is empty
   task automatic send_byte(input logic [7:0] v);
      tx_wdata = v;
      tx_wr = 1'b1;
      @(negedge ref_clk);
      tx_wr = 1'b0;
   endtask : send_byte
   task automatic clr();
      repeat (4) begin
         rx_rd = 1'b1;
         sv_rd = 1'b1;
         @(negedge ref_clk);
         rx_rd = 1'b0;
         sv_rd = 1'b0;
         repeat (3) @(negedge ref_clk);
      end
   endtask : clr
   initial begin
      repeat (10) @(negedge ref_clk);
      `CHK("empty at reset", 1'b1, tx_holding_empty_flag)
      `CHK("vector at reset", SV_NONE, state_vector_reg)
      `CHK("drive at reset", 1'b0, bus_tx_out)
      repeat (6) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (6000) @(negedge ref_clk);
      done("reset");
      for (int i = 0; i < 4; i++) begin
         pulse_fast(rows[i].fast);
         irq_enable_bit = rows[i].ie;
         clr();
         u_node.frame(rows[i].d, rows[i].n, rows[i].bad);
         repeat (8) @(negedge ref_clk);
         `CHK("full flag", rows[i].fast, rx_byte_full_flag)
         `CHK("vector", rows[i].vec, state_vector_reg)
         `CHK("irq", rows[i].ie, irq)
         `CHK("ifr flag", 1'b0, inframe_resp_rx_flag)
         if (rows[i].fast) `CHK("last byte", u_node.crc8(rows[i].d, rows[i].n) ^ {7'h00, rows[i].bad}, rx_data)
         done("frame row");
      end
      pulse_fast(1'b1);
      clr();
      u_node.sym(1'b1, int'(RX_BRK_US) + 20, FAST_TICK_CYC);
      u_node.sym(1'b0, 1, FAST_TICK_CYC);
      `CHK("fast bit after break", 1'b0, fast_receive_bit)
      `CHK("vector after break", SV_INV, state_vector_reg)
      clr();
      `CHK("vector read clears", 1'b0, state_vector_reg === SV_INV)
      done("break");
      stuck_hi = 1'b1;
      repeat (4) @(negedge ref_clk);
      send_byte(8'h5a);
      repeat (8000) @(negedge ref_clk);
      `CHK("no drive on stuck bus", 1'b0, bus_tx_out)
      `CHK("vector on stuck bus", SV_INV, state_vector_reg)
      stuck_hi = 1'b0;
      stuck_lo = 1'b1;
      clr();
      `WAITC(bus_tx_out === 1'b1, 8000)
      `CHK("drive after fault", 1'b1, bus_tx_out)
      `CHK("byte moved to shift", 1'b1, tx_holding_empty_flag)
      `WAITC(bus_tx_out === 1'b0, 200)
      repeat (4) @(negedge ref_clk);
      `CHK("vector on dead bus", SV_INV, state_vector_reg)
      `CHK("no loa on dead bus", 1'b0, lost_arbitration_flag)
      `WAITC(bus_tx_out === 1'b1, 600)
      `CHK("no retry", 1'b0, bus_tx_out)
      done("bus faults");
      // the pin stays stuck active, so only the looped path can deliver the byte
      stuck_lo = 1'b0;
      stuck_hi = 1'b1;
      digital_loopback_bit = 1'b1;
      clr();
      send_byte(8'hc3);
      `WAITC(rx_byte_full_flag === 1'b1, 32000)
      `CHK("looped byte", 8'hc3, rx_data)
      done("loopback");
      report_and_stop();
   end
endmodule : vpw_link_core_tb_top
